// ===== hw/spo_pulse_core.sv
`timescale 1ns/1ps

module spo_pulse_core (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic reg_wr_i,
    input wire logic [1:0] reg_lane_i,
    input wire logic [7:0] reg_data_i,
    input wire logic origin_input_n_i,
    input wire logic slowdown_input_n_i,
    input wire logic end_limit_input_n_i,
    input wire logic stop_input_n_i,
    output logic step_o,
    output logic dir_minus_o,
    output logic busy_o,
    output logic stop_irq_o,
    output logic auto_ramp_down_o,
    output logic [23:0] feed_amount_count_o,
    output logic [23:0] current_position_counter_o,
    output logic [12:0] speed_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    spo_pkg::spo_state_e state;
    logic [7:0] ctrl_mode;
    logic [7:0] out_mode;
    logic [7:0] reg_select;
    logic [23:0] write_buf;
    logic [23:0] env_setting;
    logic [12:0] start_speed_setting;
    logic [12:0] run_speed_setting;
    logic [15:0] ramp_rate_setting;
    logic [9:0] speed_multiplier;
    logic [7:0] start_code;
    logic [23:0] accel_pulses;
    logic decel_req;
    logic decel_stop_req;
    logic irq_on_stop;
    logic tick;
    logic [12:0] load_speed;
    logic [12:0] target_speed;
    logic running;
    logic origin_mode;
    logic count_limit;
    logic timer_mode;
    logic start_cmd;
    logic start_blocked;
    logic reg_commit;
    logic [23:0] commit_value;
    logic stop_now;
    logic halt_count;

    // Start commands: sequence bit set, stop bit clear
    function automatic logic is_start(input logic [7:0] code);
        is_start = (code[7:6] == spo_pkg::GRP_START) && code[spo_pkg::START_SEQ_BIT]
            && !code[spo_pkg::START_STOPCMD_BIT];
    endfunction : is_start

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign running = (state == spo_pkg::ST_RUN);
    assign origin_mode = ctrl_mode[spo_pkg::CTRL_ORIGIN_BIT];
    assign count_limit = ctrl_mode[spo_pkg::CTRL_LIMIT_BIT];
    assign timer_mode = out_mode[spo_pkg::OUT_MASK_BIT];
    assign halt_count = env_setting[spo_pkg::ENV_HALT_BIT];
    assign auto_ramp_down_o = env_setting[spo_pkg::ENV_AUTO_RAMP_BIT];
    assign start_cmd = cmd_wr_i && is_start(cmd_data_i) && !running;
    // Zero feed or origin already reached refuses motion
    assign start_blocked = (count_limit && feed_amount_count_o == 24'h000000)
        || (origin_mode && !timer_mode && !origin_input_n_i);
    assign busy_o = running;
    assign dir_minus_o = ctrl_mode[spo_pkg::CTRL_DIR_BIT];

    // ------------------------------------------------------------
    // Command buffer
    // ------------------------------------------------------------
    // Mode and selection latches
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_mode <= spo_pkg::CTRL_RST;
            out_mode <= spo_pkg::OUT_RST;
            reg_select <= spo_pkg::SEL_FEED;
        end else if (cmd_wr_i) begin
            if (cmd_data_i[7:6] == spo_pkg::GRP_CTRL) begin
                ctrl_mode <= cmd_data_i;
            end else if (cmd_data_i[7:6] == spo_pkg::GRP_OUTPUT) begin
                out_mode <= cmd_data_i;
            end else if (cmd_data_i[7:6] == spo_pkg::GRP_SELECT) begin
                reg_select <= cmd_data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Register write buffer
    // ------------------------------------------------------------
    // Lower byte commits; a skipped upper byte keeps its last value
    assign reg_commit = reg_wr_i && (reg_lane_i == spo_pkg::LANE_LOWER);
    assign commit_value = {write_buf[23:8], reg_data_i};

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_buf <= '0;
        end else if (reg_wr_i) begin
            if (reg_lane_i == spo_pkg::LANE_UPPER) begin
                write_buf[23:16] <= reg_data_i;
            end else if (reg_lane_i == spo_pkg::LANE_MIDDLE) begin
                write_buf[15:8] <= reg_data_i;
            end else begin
                write_buf[7:0] <= reg_data_i;
            end
        end
    end

    // Setting registers loaded on commit
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            env_setting <= spo_pkg::ENV_RST;
            start_speed_setting <= spo_pkg::SPEED_RST;
            run_speed_setting <= spo_pkg::SPEED_RST;
            ramp_rate_setting <= spo_pkg::RAMP_RST;
            speed_multiplier <= spo_pkg::MULT_UNITY;
        end else if (reg_commit) begin
            if (reg_select == spo_pkg::SEL_ENV) begin
                env_setting <= commit_value;
            end else if (reg_select == spo_pkg::SEL_START_SPEED) begin
                start_speed_setting <= commit_value[12:0];
            end else if (reg_select == spo_pkg::SEL_RUN_SPEED) begin
                run_speed_setting <= commit_value[12:0];
            end else if (reg_select == spo_pkg::SEL_RAMP) begin
                ramp_rate_setting <= commit_value[15:0];
            end else if (reg_select == spo_pkg::SEL_MULT) begin
                speed_multiplier <= commit_value[9:0];
            end
        end
    end

    // Feed amount: loaded by host, counted down per pulse
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            feed_amount_count_o <= '0;
        end else if (running && tick && count_limit) begin
            feed_amount_count_o <= feed_amount_count_o - 24'h000001;
        end else if (reg_commit && reg_select == spo_pkg::SEL_FEED) begin
            feed_amount_count_o <= commit_value;
        end
    end

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    // Stop sources by priority of mode
    always_comb begin
        stop_now = 1'b0;
        if (!stop_input_n_i || (cmd_wr_i && cmd_data_i == spo_pkg::CMD_IMM_STOP)) begin
            stop_now = 1'b1;
        end else if (count_limit && tick && feed_amount_count_o == 24'h000001) begin
            stop_now = 1'b1;
        end else if (decel_stop_req && speed_o == start_speed_setting) begin
            stop_now = 1'b1;
        end else if (!timer_mode && !end_limit_input_n_i) begin
            stop_now = 1'b1;
        end else if (!timer_mode && origin_mode && !origin_input_n_i) begin
            stop_now = 1'b1;
        end
    end

    // Idle / run sequencing
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= spo_pkg::ST_IDLE;
            start_code <= '0;
        end else begin
            case (state)
                spo_pkg::ST_IDLE: begin
                    if (start_cmd) begin
                        start_code <= cmd_data_i;
                        if (!start_blocked) begin
                            state <= spo_pkg::ST_RUN;
                        end
                    end
                end
                spo_pkg::ST_RUN: begin
                    if (stop_now) begin
                        state <= spo_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= spo_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Stop interrupt: set at stop or refused start, cleared by next start
    assign irq_on_stop = cmd_data_i[spo_pkg::START_INT_BIT];
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_irq_o <= 1'b0;
        end else if (start_cmd && start_blocked && irq_on_stop) begin
            stop_irq_o <= 1'b1;
        end else if (running && stop_now && start_code[spo_pkg::START_INT_BIT]) begin
            stop_irq_o <= 1'b1;
        end else if (start_cmd) begin
            stop_irq_o <= 1'b0;
        end
    end

    // Deceleration requests and acceleration pulse count
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            decel_req <= 1'b0;
            decel_stop_req <= 1'b0;
            accel_pulses <= '0;
        end else if (!running) begin
            decel_req <= 1'b0;
            decel_stop_req <= 1'b0;
            accel_pulses <= '0;
        end else begin
            if (ctrl_mode[spo_pkg::CTRL_SLOW_BIT] && !slowdown_input_n_i) begin
                decel_req <= 1'b1;
            end
            if (cmd_wr_i && cmd_data_i == spo_pkg::CMD_DECEL_STOP) begin
                decel_req <= 1'b1;
                decel_stop_req <= 1'b1;
            end
            if (auto_ramp_down_o && count_limit && start_code[spo_pkg::START_RAMP_BIT]
                && feed_amount_count_o <= accel_pulses) begin
                decel_req <= 1'b1;
            end
            if (tick && !decel_req && speed_o != run_speed_setting) begin
                accel_pulses <= accel_pulses + 24'h000001;
            end
        end
    end

    // Speed selection from start code
    assign load_speed = start_code[spo_pkg::START_FH_BIT] && !start_code[spo_pkg::START_RAMP_BIT]
        ? run_speed_setting : start_speed_setting;
    assign target_speed = decel_req ? start_speed_setting
        : (start_code[spo_pkg::START_RAMP_BIT] ? run_speed_setting : load_speed);

    spo_pulse_gen u_gen (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(running),
        .load_speed_i(load_speed),
        .target_speed_i(target_speed),
        .ramp_rate_i(ramp_rate_setting),
        .multiplier_i(speed_multiplier),
        .tick_o(tick),
        .speed_o(speed_o)
    );

    // ------------------------------------------------------------
    // Pulse output and position counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_o <= 1'b0;
        end else begin
            step_o <= tick && !out_mode[spo_pkg::OUT_INHIBIT_BIT] && !timer_mode;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            current_position_counter_o <= '0;
        end else if (tick && !halt_count) begin
            if (dir_minus_o) begin
                current_position_counter_o <= current_position_counter_o - 24'h000001;
            end else begin
                current_position_counter_o <= current_position_counter_o + 24'h000001;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_feed_count_down: assert property (
        running && tick && count_limit |=> feed_amount_count_o == $past(feed_amount_count_o) - 24'h1)
        else $error("feed count did not decrement");
    a_feed_zero_stop: assert property (
        running && count_limit && tick && feed_amount_count_o == 24'h1
        |=> state == spo_pkg::ST_IDLE && feed_amount_count_o == 24'h0)
        else $error("run did not end at zero feed");
    a_origin_stop: assert property (
        running && origin_mode && !timer_mode && !origin_input_n_i |=> !running)
        else $error("origin input did not stop run");
    a_zero_start_irq: assert property (
        start_cmd && count_limit && feed_amount_count_o == 24'h0 && irq_on_stop
        |=> !running && stop_irq_o)
        else $error("zero feed start moved or gave no interrupt");
    a_pulse_gate: assert property (
        step_o |-> $past(tick) && !$past(out_mode[spo_pkg::OUT_INHIBIT_BIT]) && !$past(timer_mode))
        else $error("pulse passed while inhibited");
    a_count_halt: assert property (
        halt_count |=> $stable(current_position_counter_o))
        else $error("position moved while halted");
    a_stop_input: assert property (
        running && !stop_input_n_i |=> !running [*2])
        else $error("stop input ignored");
    a_timer_ignore: assert property (
        running && timer_mode && stop_input_n_i && !cmd_wr_i && !decel_stop_req
        && !(count_limit && tick && feed_amount_count_o == 24'h1) |=> running)
        else $error("timer run stopped by limit or origin");
    a_dir_hold: assert property (
        running && !cmd_wr_i |=> dir_minus_o == $past(dir_minus_o))
        else $error("direction changed without command");

    c_position_done: cover property (running ##1 !running && feed_amount_count_o == 24'h0);
    c_origin_stop: cover property (running && origin_mode && !origin_input_n_i ##1 !running);
    c_timer_irq: cover property (running && timer_mode ##[1:1000] stop_irq_o);
    c_blocked_start: cover property (start_cmd && start_blocked);

endmodule : spo_pulse_core

// ===== hw/spo_pkg.sv
package spo_pkg;

    // ----------------------------------------------------------------
    // Clock and widths
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int unsigned FEED_W = 24;
    localparam int unsigned SPEED_W = 13;
    localparam int unsigned RAMP_W = 16;
    localparam int unsigned MULT_W = 10;
    localparam int unsigned ACC_W = 40;

    // ----------------------------------------------------------------
    // Command groups (top two bits of a command byte)
    // ----------------------------------------------------------------
    localparam logic [1:0] GRP_START = 2'h0;
    localparam logic [1:0] GRP_CTRL = 2'h1;
    localparam logic [1:0] GRP_SELECT = 2'h2;
    localparam logic [1:0] GRP_OUTPUT = 2'h3;

    // Register selection codes
    localparam logic [7:0] SEL_FEED = 8'h80;
    localparam logic [7:0] SEL_START_SPEED = 8'h81;
    localparam logic [7:0] SEL_RUN_SPEED = 8'h82;
    localparam logic [7:0] SEL_RAMP = 8'h83;
    localparam logic [7:0] SEL_MULT = 8'h84;
    localparam logic [7:0] SEL_ENV = 8'h87;

    // Stop commands
    localparam logic [7:0] CMD_IMM_STOP = 8'h08;
    localparam logic [7:0] CMD_DECEL_STOP = 8'h1d;

    // Start mode command fields
    localparam int unsigned START_FH_BIT = 0;
    localparam int unsigned START_RAMP_BIT = 2;
    localparam int unsigned START_STOPCMD_BIT = 3;
    localparam int unsigned START_SEQ_BIT = 4;
    localparam int unsigned START_INT_BIT = 5;

    // Control mode command fields
    localparam int unsigned CTRL_ORIGIN_BIT = 0;
    localparam int unsigned CTRL_SLOW_BIT = 1;
    localparam int unsigned CTRL_LIMIT_BIT = 2;
    localparam int unsigned CTRL_DIR_BIT = 3;

    // Output mode command fields
    localparam int unsigned OUT_MASK_BIT = 1;
    localparam int unsigned OUT_INHIBIT_BIT = 2;

    // Environment setting fields
    localparam int unsigned ENV_AUTO_RAMP_BIT = 3;
    localparam int unsigned ENV_HALT_BIT = 8;

    // Register write buffer byte lanes
    localparam logic [1:0] LANE_LOWER = 2'h0;
    localparam logic [1:0] LANE_MIDDLE = 2'h1;
    localparam logic [1:0] LANE_UPPER = 2'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [7:0] OUT_RST = 8'he0;
    localparam logic [23:0] ENV_RST = 24'h000000;
    localparam logic [12:0] SPEED_RST = 13'h0001;
    localparam logic [15:0] RAMP_RST = 16'h0001;
    localparam logic [9:0] MULT_UNITY = 10'h258;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } spo_state_e;

endpackage : spo_pkg

// ===== hw/spo_pulse_gen.sv
`timescale 1ns/1ps

// Rate generator: speed ramps toward a target, ticks at speed times MULT_UNITY divided by multiplier
module spo_pulse_gen (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [12:0] load_speed_i,
    input wire logic [12:0] target_speed_i,
    input wire logic [15:0] ramp_rate_i,
    input wire logic [9:0] multiplier_i,
    output logic tick_o,
    output logic [12:0] speed_o
);

    logic [39:0] acc;
    logic [39:0] step_add;
    logic [39:0] limit;
    logic [39:0] acc_sum;
    logic [15:0] ramp_cnt;

    // ------------------------------------------------------------
    // Phase accumulator
    // ------------------------------------------------------------
    // Unity multiplier makes one speed unit equal one pulse per second
    assign step_add = 40'(speed_o) * 40'(spo_pkg::MULT_UNITY);
    assign limit = 40'(spo_pkg::CLK_HZ) * 40'(multiplier_i);
    assign acc_sum = acc + step_add;
    assign tick_o = run_i && (acc_sum >= limit);

    // Accumulator restarts at every run
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc <= '0;
        end else if (!run_i) begin
            acc <= '0;
        end else if (tick_o) begin
            acc <= acc_sum - limit;
        end else begin
            acc <= acc_sum;
        end
    end

    // ------------------------------------------------------------
    // Speed ramp, one step per ramp_rate clocks
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_o <= spo_pkg::SPEED_RST;
            ramp_cnt <= '0;
        end else if (!run_i) begin
            speed_o <= load_speed_i;
            ramp_cnt <= '0;
        end else if (speed_o == target_speed_i) begin
            ramp_cnt <= '0;
        end else if (ramp_cnt + 16'h0001 >= ramp_rate_i) begin
            ramp_cnt <= '0;
            if (speed_o < target_speed_i) begin
                speed_o <= speed_o + 13'h0001;
            end else begin
                speed_o <= speed_o - 13'h0001;
            end
        end else begin
            ramp_cnt <= ramp_cnt + 16'h0001;
        end
    end

endmodule : spo_pulse_gen

// ===== tb/spo_motor_model.sv
`timescale 1ns/1ps

// Driver and sensor side: counts steps, trips the origin sensor at a set count
module spo_motor_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic step_i,
    input wire logic clr_i,
    input wire logic [7:0] origin_at_i,
    output logic origin_input_n_o,
    output logic [7:0] step_count_o
);
    // Steps seen since the last clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_count_o <= 8'h00;
        end else if (clr_i) begin
            step_count_o <= 8'h00;
        end else if (step_i) begin
            step_count_o <= step_count_o + 8'h01;
        end
    end

    // Origin switch closes once the carriage reaches it; zero disarms it
    assign origin_input_n_o = !((origin_at_i != 8'h00) && (step_count_o >= origin_at_i));
endmodule : spo_motor_model

// ===== tb/stepper_pulse_operation_modes_tb_top.sv
`timescale 1ns/1ps

module stepper_pulse_operation_modes_tb_top;
    typedef struct {int sel; string name; logic [23:0] exp;} spo_note_s;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_wr = 1'b0, reg_wr = 1'b0, clr = 1'b0, limit_n = 1'b1, stop_n = 1'b1;
    logic slow_n = 1'b1;
    logic [12:0] speed;
    logic [7:0] cmd_data = 8'h00, reg_data = 8'h00, origin_at = 8'h00, steps;
    logic [1:0] reg_lane = 2'h0;
    logic origin_n, step_o, dir_minus_o, busy_o, stop_irq_o, auto_ramp_down_o;
    logic [23:0] feed, pos, exp_pos = 24'h000000;
    logic [31:0] lfsr = 32'h5b757177;
    int mismatches = 0, samples_checked = 0;
    spo_note_s notes[$];
    event ev;

    spo_pulse_core uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_wr_i(cmd_wr),
        .cmd_data_i(cmd_data), .reg_wr_i(reg_wr), .reg_lane_i(reg_lane), .reg_data_i(reg_data),
        .origin_input_n_i(origin_n), .slowdown_input_n_i(slow_n), .end_limit_input_n_i(limit_n),
        .stop_input_n_i(stop_n), .step_o(step_o), .dir_minus_o(dir_minus_o), .busy_o(busy_o),
        .stop_irq_o(stop_irq_o), .auto_ramp_down_o(auto_ramp_down_o),
        .feed_amount_count_o(feed), .current_position_counter_o(pos), .speed_o(speed));
    spo_motor_model motor (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .step_i(step_o),
        .clr_i(clr), .origin_at_i(origin_at), .origin_input_n_o(origin_n), .step_count_o(steps));

    // Clock and watchdog
    initial forever #2 ref_clk_i = ~ref_clk_i;
    initial begin
        #(50_000 * 4);
        mismatches++;
        wrap_up();
    end

    // ----
    // Host tasks
    // ----
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic cmd(input logic [7:0] b);
        @(negedge ref_clk_i);
        cmd_wr = 1'b1;
        cmd_data = b;
        @(negedge ref_clk_i);
        cmd_wr = 1'b0;
    endtask : cmd
    task automatic wr_reg(input logic [7:0] sel, input logic [23:0] v, input bit up);
        cmd(sel);
        for (int l = 2; l >= 0; l--) begin
            if (l < 2 || up) begin
                @(negedge ref_clk_i);
                reg_wr = 1'b1;
                reg_lane = l[1:0];
                reg_data = v[8*l +: 8];
                @(negedge ref_clk_i);
                reg_wr = 1'b0;
            end
        end
    endtask : wr_reg
    task automatic run(input logic [7:0] code, input bit keep);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        clr = !keep;
        @(negedge ref_clk_i);
        clr = 1'b0;
        cmd(code);
        repeat (2) @(negedge ref_clk_i);
        while (busy_o !== 1'b0 && n < 30000) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 30000) mismatches++;
    endtask : run
    task automatic pos_run(input logic [7:0] ctl, out, code, input logic [23:0] n);
        cmd(ctl);
        cmd(out);
        wr_reg(8'h80, n, 1'b1);
        run(code, 1'b0);
    endtask : pos_run
    task automatic note(input int sel, input string name, input logic [23:0] exp);
        notes.push_back('{sel, name, exp});
    endtask : note
    task automatic flush;
        // Last step reaches the motor model one edge after busy falls
        @(negedge ref_clk_i);
        -> ev;
        @(negedge ref_clk_i);
    endtask : flush
    task automatic wrap_up;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // Monitor: compares each settled output against the oldest note
    initial begin
        spo_note_s n;
        logic [23:0] seen;
        forever begin
            @(ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                case (n.sel)
                    0: seen = {16'h0000, steps};
                    1: seen = feed;
                    2: seen = pos;
                    3: seen = {23'h0, stop_irq_o};
                    4: seen = {23'h0, dir_minus_o};
                    5: seen = {23'h0, busy_o};
                    7: seen = {11'h000, speed};
                    default: seen = {23'h0, auto_ramp_down_o};
                endcase
                samples_checked++;
                if (seen !== n.exp) begin
                    mismatches++;
                    $display("BAD %s expected %h seen %h", n.name, n.exp, seen);
                end
            end
        end
    end

    // Main sequence
    initial begin
        logic [7:0] codes [3];
        logic [23:0] n;
        codes = '{8'h30, 8'h11, 8'h15};
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        wr_reg(8'h87, 24'h00000a, 1'b1);
        note(6, "auto_ramp", 24'h1);
        wr_reg(8'h81, 24'h001fff, 1'b0);
        wr_reg(8'h82, 24'h001fff, 1'b1);
        wr_reg(8'h84, 24'h000002, 1'b0);
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            n = {21'h0, lfsr[2:0]} + 24'h1;
            exp_pos = (i == 1) ? exp_pos - n : exp_pos + n;
            pos_run(i == 1 ? 8'h4c : 8'h44, 8'he0, codes[i], n);
            note(0, "steps", n);
            note(1, "feed", 24'h0);
            note(2, "position", exp_pos);
            note(4, "dir_minus", {23'h0, i == 1});
            note(3, "stop_irq", {23'h0, i == 0});
            flush();
        end
        run(8'h30, 1'b0);
        note(0, "steps", 24'h0);
        note(3, "stop_irq", 24'h1);
        flush();
        limit_n = 1'b0;
        exp_pos = exp_pos + 24'h4;
        pos_run(8'h44, 8'he2, 8'h30, 24'h4);
        note(0, "steps", 24'h0);
        note(2, "position", exp_pos);
        note(3, "stop_irq", 24'h1);
        flush();
        limit_n = 1'b1;
        wr_reg(8'h87, 24'h00010a, 1'b1);
        pos_run(8'h44, 8'he4, 8'h11, 24'h3);
        note(0, "steps", 24'h0);
        note(2, "position", exp_pos);
        flush();
        wr_reg(8'h87, 24'h00000a, 1'b1);
        origin_at = 8'h03;
        exp_pos = exp_pos + 24'h3;
        pos_run(8'h45, 8'he0, 8'h11, 24'd50);
        note(0, "steps", 24'h3);
        note(1, "feed", 24'd47);
        note(2, "position", exp_pos);
        flush();
        run(8'h30, 1'b1);
        note(0, "steps", 24'h3);
        note(3, "stop_irq", 24'h1);
        flush();
        origin_at = 8'h00;
        exp_pos = exp_pos + 24'h2;
        pos_run(8'h45, 8'he0, 8'h11, 24'h2);
        note(0, "steps", 24'h2);
        note(2, "position", exp_pos);
        flush();
        cmd(8'h44);
        cmd(8'he2);
        wr_reg(8'h80, 24'd200, 1'b1);
        cmd(8'h11);
        repeat (300) @(negedge ref_clk_i);
        note(5, "busy", 24'h1);
        flush();
        stop_n = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        note(5, "busy", 24'h0);
        flush();
        stop_n = 1'b1;
        // Slowdown enabled: speed falls to start speed, run continues
        wr_reg(8'h81, 24'h001ff0, 1'b0);
        cmd(8'h46);
        cmd(8'he0);
        wr_reg(8'h80, 24'd200, 1'b1);
        cmd(8'h11);
        repeat (20) @(negedge ref_clk_i);
        slow_n = 1'b0;
        repeat (40) @(negedge ref_clk_i);
        note(7, "speed", 24'h001ff0);
        note(5, "busy", 24'h1);
        flush();
        cmd(8'h08);
        repeat (2) @(negedge ref_clk_i);
        note(5, "busy", 24'h0);
        flush();
        slow_n = 1'b1;
        wrap_up();
    end
endmodule : stepper_pulse_operation_modes_tb_top
